// *** hw/module_power_on_off_sequencer.sv ***
// Device-side power-on and shutdown sequencer for a cellular module
// Overview of operation
// - Boot runs after turn-on; operational no earlier than 20 s after key.
// - Firmware-ready goes high only when fully powered and accepting commands.
// - Power-monitor rises once all pads and interfaces are configured.
// - Typically power-monitor at 21 s and firmware-ready at 28 s.
// - Key tied low permanently: power-on starts one key-on hold (1 s) after supply appears.
// - Shutdown command enters finalization; at its end both outputs drop.
// - Key low beyond 2.5 s enters finalization; outputs drop afterwards.
// - Both orderly shutdowns send a network detach request first.
module module_power_on_off_sequencer #(
    parameter int unsigned KEY_ON_CYC   = pwr_seq_pkg::KEY_ON_MS * pwr_seq_pkg::CYC_PER_MS,
    parameter int unsigned KEY_OFF_CYC  = pwr_seq_pkg::KEY_OFF_MS * pwr_seq_pkg::CYC_PER_MS,
    parameter int unsigned EOFF_CYC     = pwr_seq_pkg::EOFF_MS * pwr_seq_pkg::CYC_PER_MS,
    parameter int unsigned MONITOR_CYC  = pwr_seq_pkg::MONITOR_TYP_MS * pwr_seq_pkg::CYC_PER_MS,
    parameter int unsigned READY_CYC    = pwr_seq_pkg::READY_TYP_MS * pwr_seq_pkg::CYC_PER_MS,
    parameter int unsigned FINAL_CYC    = pwr_seq_pkg::FINALIZE_TYP_MS * pwr_seq_pkg::CYC_PER_MS
) (
    input  wire logic CLK,
    input  wire logic RSTN,
    input  wire logic POWER_KEY_N,
    input  wire logic EMERGENCY_OFF_N,
    input  wire logic BATTERY_SUPPLY,
    input  wire logic SHUTDOWN_COMMAND,
    input  wire logic DETACH_DONE,
    output logic      DETACH_REQUEST,
    output logic      AUX_SUPPLY_OUT,
    output logic      POWER_MONITOR,
    output logic      FIRMWARE_READY
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        pwr_seq_pkg::state_e state;
        logic [31:0]         key_cnt;
        logic [31:0]         eoff_cnt;
        logic [31:0]         tmr;
        logic                key_off_armed;
        logic                eoff_armed;
        logic                detach;
        logic                aux;
        logic                mon;
        logic                rdy;
    } seq_s;

    seq_s s_q;
    seq_s s_d;
    logic key_low;
    logic eoff_low;
    logic key_n_s;
    logic eoff_n_s;
    logic batt_s;

    pin_sync #(.RESET_VAL(1'b1)) u_key_sync (
        .clk   (CLK),
        .rstn  (RSTN),
        .pin   (POWER_KEY_N),
        .level (key_n_s)
    );

    pin_sync #(.RESET_VAL(1'b1)) u_eoff_sync (
        .clk   (CLK),
        .rstn  (RSTN),
        .pin   (EMERGENCY_OFF_N),
        .level (eoff_n_s)
    );

    pin_sync #(.RESET_VAL(1'b0)) u_batt_sync (
        .clk   (CLK),
        .rstn  (RSTN),
        .pin   (BATTERY_SUPPLY),
        .level (batt_s)
    );

    assign key_low  = !key_n_s;
    assign eoff_low = !eoff_n_s;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        // Low-time counters saturate so a stuck-low key never wraps
        if (key_low && s_q.key_cnt != 32'hFFFFFFFF)
        begin
            s_d.key_cnt = s_q.key_cnt + 32'h1;
        end
        else if (!key_low)
        begin
            s_d.key_cnt = 32'h0;
        end
        if (eoff_low && s_q.eoff_cnt != 32'hFFFFFFFF)
        begin
            s_d.eoff_cnt = s_q.eoff_cnt + 32'h1;
        end
        else if (!eoff_low)
        begin
            s_d.eoff_cnt = 32'h0;
        end
        if (eoff_low && s_q.eoff_cnt + 32'h1 >= EOFF_CYC)
        begin
            s_d.eoff_armed = 1'b1;
        end
        if (s_q.tmr != 32'hFFFFFFFF)
        begin
            s_d.tmr = s_q.tmr + 32'h1;
        end

        case (s_q.state)
            pwr_seq_pkg::ST_OFF:
            begin
                s_d.aux = 1'b0;
                s_d.mon = 1'b0;
                s_d.rdy = 1'b0;
                // Held key counts from its first low edge; a grounded key counts from supply-on and boots after the same hold
                if (batt_s && key_low && s_q.key_cnt + 32'h1 >= KEY_ON_CYC)
                begin
                    s_d.state = pwr_seq_pkg::ST_KEY_ON;
                end
            end
            pwr_seq_pkg::ST_KEY_ON:
            begin
                // Boot starts in the first key-on cycle, whether or not the key is released
                if (!key_low || !s_q.key_off_armed)
                begin
                    s_d.state = pwr_seq_pkg::ST_BOOT;
                    s_d.tmr   = 32'h0;
                    s_d.aux   = 1'b1;
                end
            end
            pwr_seq_pkg::ST_BOOT:
            begin
                if (s_q.tmr + 32'h1 >= MONITOR_CYC)
                begin
                    s_d.mon = 1'b1;
                end
                if (s_q.tmr + 32'h1 >= READY_CYC)
                begin
                    s_d.rdy   = 1'b1;
                    s_d.state = pwr_seq_pkg::ST_ACTIVE;
                end
            end
            pwr_seq_pkg::ST_ACTIVE:
            begin
                if (SHUTDOWN_COMMAND || (key_low && s_q.key_cnt + 32'h1 > KEY_OFF_CYC))
                begin
                    s_d.state  = pwr_seq_pkg::ST_DETACH;
                    s_d.detach = 1'b1;
                end
            end
            pwr_seq_pkg::ST_DETACH:
            begin
                if (DETACH_DONE)
                begin
                    s_d.detach = 1'b0;
                    s_d.tmr    = 32'h0;
                    s_d.state  = pwr_seq_pkg::ST_FINALIZE;
                end
            end
            pwr_seq_pkg::ST_FINALIZE:
            begin
                if (s_q.tmr + 32'h1 >= FINAL_CYC)
                begin
                    s_d.mon   = 1'b0;
                    s_d.rdy   = 1'b0;
                    s_d.aux   = 1'b0;
                    s_d.state = pwr_seq_pkg::ST_OFF;
                end
            end
            default:
            begin
                s_d.state = pwr_seq_pkg::ST_OFF;
            end
        endcase

        // Grounded key must not re-trigger shutdown after boot
        if (s_q.state == pwr_seq_pkg::ST_OFF)
        begin
            s_d.key_off_armed = 1'b0;
        end
        else if (!key_low)
        begin
            s_d.key_off_armed = 1'b1;
        end
        if (s_d.state == pwr_seq_pkg::ST_ACTIVE && !s_q.key_off_armed && key_low)
        begin
            s_d.key_cnt = 32'h0;
        end

        // Emergency-off and loss of supply override everything; no detach
        if (s_q.eoff_armed && !eoff_low || !batt_s)
        begin
            s_d = '0;
            s_d.state = pwr_seq_pkg::ST_OFF;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign DETACH_REQUEST = s_q.detach;
    assign AUX_SUPPLY_OUT = s_q.aux;
    assign POWER_MONITOR  = s_q.mon;
    assign FIRMWARE_READY = s_q.rdy;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    ready_after_mon_a : assert property (@(posedge CLK) disable iff (!RSTN)
        FIRMWARE_READY |-> POWER_MONITOR) else $error("ready without monitor");

    ready_only_active_a : assert property (@(posedge CLK) disable iff (!RSTN)
        FIRMWARE_READY |-> s_q.state == pwr_seq_pkg::ST_ACTIVE || s_q.state == pwr_seq_pkg::ST_DETACH
        || s_q.state == pwr_seq_pkg::ST_FINALIZE) else $error("ready outside active");

    ready_not_early_a : assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(FIRMWARE_READY) |-> $past(s_q.tmr) + 32'h1 >= READY_CYC) else $error("ready too early");

    mon_rise_time_a : assert property (@(posedge CLK) disable iff (!RSTN)
        $rose(POWER_MONITOR) |-> $past(s_q.tmr) + 32'h1 == MONITOR_CYC) else $error("monitor rise time");

    detach_first_a : assert property (@(posedge CLK) disable iff (!RSTN)
        (s_q.state == pwr_seq_pkg::ST_ACTIVE ##1 s_q.state == pwr_seq_pkg::ST_DETACH) |-> DETACH_REQUEST)
        else $error("no detach request");

    cmd_shutdown_a : assert property (@(posedge CLK) disable iff (!RSTN)
        (s_q.state == pwr_seq_pkg::ST_ACTIVE && SHUTDOWN_COMMAND && !s_d.eoff_armed && batt_s
        && !(s_q.eoff_armed && !eoff_low)) |=> s_q.state == pwr_seq_pkg::ST_DETACH)
        else $error("command not taken");

    final_drop_a : assert property (@(posedge CLK) disable iff (!RSTN)
        (s_q.state == pwr_seq_pkg::ST_FINALIZE ##1 s_q.state == pwr_seq_pkg::ST_OFF)
        |-> !POWER_MONITOR && !FIRMWARE_READY) else $error("outputs stay high");

    eoff_kill_a : assert property (@(posedge CLK) disable iff (!RSTN)
        (s_q.eoff_armed && !eoff_low) |=> !POWER_MONITOR && !FIRMWARE_READY && !AUX_SUPPLY_OUT)
        else $error("emergency off ignored");

    boot_from_key_a : assert property (@(posedge CLK) disable iff (!RSTN)
        (s_q.state == pwr_seq_pkg::ST_OFF ##1 s_q.state == pwr_seq_pkg::ST_KEY_ON)
        |-> $past(s_q.key_cnt) + 32'h1 >= KEY_ON_CYC) else $error("short key booted");
endmodule // module_power_on_off_sequencer

// *** hw/pwr_seq_pkg.sv ***
// Package of timing constants and states for the module power sequencer
package pwr_seq_pkg;

    localparam int unsigned CLK_MHZ         = 125;
    // Times in milliseconds, as documented
    localparam int unsigned KEY_ON_MS       = 1000;
    localparam int unsigned KEY_OFF_MS      = 2500;
    localparam int unsigned EOFF_MS         = 200;
    localparam int unsigned OPERATIONAL_MS  = 20000;
    localparam int unsigned MONITOR_TYP_MS  = 21000;
    localparam int unsigned READY_TYP_MS    = 28000;
    localparam int unsigned FINALIZE_TYP_MS = 10000;
    // Cycles per millisecond at the core clock
    localparam int unsigned CYC_PER_MS      = CLK_MHZ * 1000;

    typedef enum logic [2:0] {
        ST_OFF      = 3'b000,
        ST_KEY_ON   = 3'b001,
        ST_BOOT     = 3'b010,
        ST_ACTIVE   = 3'b011,
        ST_DETACH   = 3'b100,
        ST_FINALIZE = 3'b101
    } state_e;

endpackage

// *** hw/pin_sync.sv ***
// Three-stage pin synchroniser with second/third stage agreement
module pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      level
);
    typedef struct packed {
        logic [2:0] sh;
        logic       lvl;
    } sync_s;

    sync_s s_q;
    sync_s s_d;

    always_comb
    begin
        s_d     = s_q;
        s_d.sh  = {s_q.sh[1:0], pin};
        // Stage 0 feeds only stage 1; decision uses stages 1 and 2
        if (s_q.sh[1] == s_q.sh[2])
        begin
            s_d.lvl = s_q.sh[2];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            s_q <= '{sh: {3{RESET_VAL}}, lvl: RESET_VAL};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign level = s_q.lvl;
endmodule // pin_sync

// *** tb/host_model.sv ***
// Host-side model: actively driven power lines and network detach answer
module host_model
(
    input  wire logic clk,
    input  wire logic detach_request,
    output logic      power_key_n,
    output logic      emergency_off_n,
    output logic      detach_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic key_low  = 1'b0;
    logic eoff_low = 1'b0;
    logic done_q   = 1'b0;
    int   ack_delay = 0;
    int   ack_cnt   = 0;

    // Released lines are driven high by the model itself, not by a pull-up
    assign power_key_n     = key_low ? 1'b0 : 1'b1;
    assign emergency_off_n = eoff_low ? 1'b0 : 1'b1;
    assign detach_done     = done_q;

    task automatic press_key(input int n);
        @(negedge clk) key_low = 1'b1;
        repeat (n) @(negedge clk);
        key_low = 1'b0;
    endtask

    task automatic press_eoff(input int n);
        @(negedge clk) eoff_low = 1'b1;
        repeat (n) @(negedge clk);
        eoff_low = 1'b0;
    endtask

    // Slow or prompt answer, held until the request is withdrawn
    always @(negedge clk)
    begin
        if (!detach_request)
        begin
            ack_cnt <= 0;
            done_q  <= 1'b0;
        end
        else if (ack_cnt >= ack_delay)
            done_q <= 1'b1;
        else
            ack_cnt <= ack_cnt + 1;
    end
endmodule // host_model

// *** tb/tb.sv ***
// Self-checking bench for the module power sequencer
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int KON = 20;
    localparam int KOFF = 50;
    localparam int MON = 100;
    localparam int RDY = 150;
    localparam int FIN = 80;

    logic       CLK = 1'b0;
    logic       RSTN = 1'b0;
    logic       supply = 1'b1;
    logic       cmd = 1'b0;
    wire        key_n;
    wire        eoff_n;
    wire        done;
    logic       req;
    logic       aux;
    logic       pmon;
    logic       fwrdy;
    wire  [3:0] obs = {req, aux, pmon, fwrdy};
    int         num_errors = 0;
    int         check_count = 0;

    initial forever #4 CLK = ~CLK;

    module_power_on_off_sequencer #(.KEY_ON_CYC(KON), .KEY_OFF_CYC(KOFF), .EOFF_CYC(10),
        .MONITOR_CYC(MON), .READY_CYC(RDY), .FINAL_CYC(FIN)) DUT (
        .CLK(CLK), .RSTN(RSTN), .POWER_KEY_N(key_n), .EMERGENCY_OFF_N(eoff_n),
        .BATTERY_SUPPLY(supply), .SHUTDOWN_COMMAND(cmd), .DETACH_DONE(done),
        .DETACH_REQUEST(req), .AUX_SUPPLY_OUT(aux), .POWER_MONITOR(pmon), .FIRMWARE_READY(fwrdy));

    host_model host (.clk(CLK), .detach_request(req), .power_key_n(key_n),
        .emergency_off_n(eoff_n), .detach_done(done));

    task automatic end_sim;
        $display("Checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %0b seen %0b", what, exp, got);
        end
    endtask

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    // Bounded wait on one output; a hang ends the run
    task automatic wait_bit(input int idx, input logic v, input int max, output int n);
        n = 0;
        while (obs[idx] !== v)
        begin
            @(negedge CLK);
            n++;
            if (n > max)
            begin
                num_errors++;
                $display("CHECK FAILED output %0d expected %0b seen %0b", idx, v, obs[idx]);
                // Host gives up waiting and forces the module off
                host.press_eoff(15);
                end_sim();
            end
        end
    endtask

    task automatic short_key;
        host.press_key(KON / 2);
        repeat (60) @(negedge CLK);
        chk("aux after short key", 1'b0, aux);
    endtask

    task automatic boot;
        int n;
        host.press_key(KON + 5);
        wait_bit(2, 1'b1, 20, n);
        chk("monitor at boot start", 1'b0, pmon);
        wait_bit(1, 1'b1, MON + 5, n);
        chk_rng("monitor delay", MON - 3, MON + 3, n);
        chk("ready before monitor", 1'b0, fwrdy);
        wait_bit(0, 1'b1, RDY, n);
        chk_rng("ready delay", RDY - MON - 3, RDY - MON + 3, n);
    endtask

    task automatic off_done(input int max);
        int n;
        wait_bit(1, 1'b0, max, n);
        chk_rng("finalize time", FIN - 3, FIN + 3, n);
        chk("ready off", 1'b0, fwrdy);
        chk("aux off", 1'b0, aux);
    endtask

    task automatic sw_off;
        int n;
        host.ack_delay = 30;
        chk("ready before command", 1'b1, fwrdy);
        @(negedge CLK) cmd = 1'b1;
        @(negedge CLK) cmd = 1'b0;
        wait_bit(3, 1'b1, 3, n);
        chk("monitor during detach", 1'b1, pmon);
        wait_bit(3, 1'b0, 40, n);
        off_done(FIN + 5);
        @(negedge CLK) supply = 1'b0;
        repeat (5) @(negedge CLK);
        supply = 1'b1;
    endtask

    task automatic key_off;
        int n;
        host.ack_delay = 0;
        fork
            host.press_key(KOFF + 10);
            begin
                wait_bit(3, 1'b1, KOFF + 12, n);
                chk_rng("key off hold", KOFF, KOFF + 8, n);
                wait_bit(3, 1'b0, 5, n);
                // Finalize counts from the detach answer, not from key release
                off_done(FIN + 5);
            end
        join
    endtask

    task automatic eoff;
        int n;
        host.press_eoff(15);
        wait_bit(1, 1'b0, 8, n);
        chk("aux after forced off", 1'b0, aux);
        chk("ready after forced off", 1'b0, fwrdy);
        chk("no detach on forced off", 1'b0, req);
    endtask

    task automatic grounded;
        int n;
        @(negedge CLK) supply = 1'b0;
        host.key_low = 1'b1;
        repeat (5) @(negedge CLK);
        supply = 1'b1;
        wait_bit(2, 1'b1, KON + 12, n);
        wait_bit(1, 1'b1, MON + 5, n);
        chk_rng("grounded monitor delay", MON - 3, MON + 3, n);
        @(negedge CLK) supply = 1'b0;
        wait_bit(1, 1'b0, 6, n);
        chk("aux after supply loss", 1'b0, aux);
        host.key_low = 1'b0;
        supply = 1'b1;
    endtask

    initial
    begin
        repeat (12) @(negedge CLK);
        RSTN = 1'b1;
        chk("monitor after reset", 1'b0, pmon);
        chk("ready after reset", 1'b0, fwrdy);
        repeat (4) @(negedge CLK);
        short_key();
        boot();
        sw_off();
        boot();
        key_off();
        boot();
        eoff();
        grounded();
        end_sim();
    end
endmodule // tb
